// *** logic/rtcc_defs.svh ***
// offsets, field positions, reset values and counts of the rtc control block
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH
`define RTCC_ADDR_COUNTER0 8'h40
`define RTCC_ADDR_COUNTER4 8'h44
`define RTCC_ADDR_MATCH0 8'h48
`define RTCC_ADDR_MATCH4 8'h4c
`define RTCC_ADDR_MBIT0 8'h50
`define RTCC_ADDR_MBIT4 8'h54
`define RTCC_ADDR_CTRL 8'h58
`define RTCC_CTRL_RESET 8'h00
`define RTCC_BIT_RTC_RST 7
`define RTCC_BIT_CNT_EN 6
`define RTCC_BIT_WAKE_EN 5
`define RTCC_BIT_MODE_HI 4
`define RTCC_BIT_MODE_LO 3
`define RTCC_BIT_CLR_MAT 2
`define RTCC_BIT_CNT_RSTB 1
`define RTCC_BIT_XTAL_SEL 0
`define RTCC_CNT_WIDTH 40
`define RTCC_PRESC_DIV 128
`define RTCC_FIRST_EDGES 64
`define RTCC_PRESC_WIDTH 7
`endif

// *** logic/rtcc_pkg.sv ***
// types of the rtc control block
package rtcc_pkg;
  typedef enum logic [3:0] {
    RTCC_ST_RUN = 4'h1,
    RTCC_ST_RESET = 4'h2,
    RTCC_ST_REL1 = 4'h4,
    RTCC_ST_REL2 = 4'h8
  } rtcc_rst_e;
  typedef logic [39:0] rtcc_cnt_t;
endpackage

// *** logic/rtcc_top.sv ***
// rtc control/status register, prescaler, 40-bit counter and match outputs
`timescale 1ns/100ps
`include "rtcc_defs.svh"
module rtcc_top #(
  parameter int CNT_W = `RTCC_CNT_WIDTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic timebase_clock,
  input wire logic [7:0] acm_addr,
  input wire logic [7:0] acm_wdata,
  input wire logic acm_wen,
  input wire logic acm_ren,
  output logic [7:0] acm_rdata,
  output logic fabric_match_out,
  output logic sequencer_match_out,
  output logic [1:0] crystal_mode_out,
  output logic crystal_select_out
);
  localparam int NB = CNT_W / 8;
  localparam logic [6:0] PRESC_LAST = 7'(`RTCC_PRESC_DIV - 1);
  localparam logic [6:0] PRESC_START =
    7'(`RTCC_PRESC_DIV - `RTCC_FIRST_EDGES);

  logic [7:0] ctrl_q, ctrl_d;
  rtcc_pkg::rtcc_rst_e rst_q, rst_d;
  logic tb_q, tb_d;
  logic [`RTCC_PRESC_WIDTH-1:0] presc_q, presc_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, match_q, match_d, hold_q, hold_d;
  logic fab_q, fab_d, seq_q, seq_d;
  logic [7:0] rdata_q, rdata_d;
  logic rtc_rst, cnt_en, tb_rise, tick, eq_now, mat_zero, eq_next;
  logic [7:0] wbyte [NB];
  logic [NB-1:0] cnt_wsel, mat_wsel;

  assign rtc_rst = (rst_q != rtcc_pkg::RTCC_ST_RUN);
  assign cnt_en = ctrl_q[`RTCC_BIT_CNT_EN] & ~rtc_rst;
  assign tb_rise = timebase_clock & ~tb_q;
  assign tick = cnt_en & tb_rise & (presc_q == PRESC_LAST);
  assign eq_now = (cnt_q == match_q);
  assign mat_zero = (match_q == '0);
  assign eq_next = (cnt_d == match_d);

  // per-byte write decode of counter and match registers
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_byte
      assign cnt_wsel[gi] = acm_wen &
        (acm_addr == 8'(`RTCC_ADDR_COUNTER0 + gi));
      assign mat_wsel[gi] = acm_wen &
        (acm_addr == 8'(`RTCC_ADDR_MATCH0 + gi));
      assign wbyte[gi] = acm_wdata;
    end
  endgenerate

  // control register and rtc reset release sequence
  always_comb begin
    ctrl_d = ctrl_q;
    if (acm_wen && acm_addr == `RTCC_ADDR_CTRL) begin
      ctrl_d = acm_wdata;
    end
    rst_d = rst_q;
    case (rst_q)
      rtcc_pkg::RTCC_ST_RUN: begin
        if (ctrl_q[`RTCC_BIT_RTC_RST]) rst_d = rtcc_pkg::RTCC_ST_RESET;
      end
      rtcc_pkg::RTCC_ST_RESET: begin
        if (!ctrl_q[`RTCC_BIT_RTC_RST]) begin
          rst_d = rtcc_pkg::RTCC_ST_REL1;
        end
      end
      rtcc_pkg::RTCC_ST_REL1: begin
        rst_d = ctrl_q[`RTCC_BIT_RTC_RST] ? rtcc_pkg::RTCC_ST_RESET :
                rtcc_pkg::RTCC_ST_REL2;
      end
      rtcc_pkg::RTCC_ST_REL2: begin
        rst_d = ctrl_q[`RTCC_BIT_RTC_RST] ? rtcc_pkg::RTCC_ST_RESET :
                rtcc_pkg::RTCC_ST_RUN;
      end
      default: rst_d = rtcc_pkg::RTCC_ST_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `RTCC_CTRL_RESET;
      rst_q <= rtcc_pkg::RTCC_ST_RUN;
    end else begin
      ctrl_q <= ctrl_d;
      rst_q <= rst_d;
    end
  end

  // prescaler, counter and match register
  always_comb begin
    tb_d = timebase_clock;
    presc_d = presc_q;
    if (!cnt_en) begin
      presc_d = PRESC_START;
    end else if (tb_rise) begin
      presc_d = presc_q + 7'h01;
    end
    match_d = match_q;
    for (int i = 0; i < NB; i++) begin
      if (mat_wsel[i]) match_d[i*8 +: 8] = wbyte[i];
    end
    cnt_d = cnt_q;
    if (rtc_rst || !ctrl_q[`RTCC_BIT_CNT_RSTB]) begin
      cnt_d = '0;
    end else if (!ctrl_q[`RTCC_BIT_CNT_EN]) begin
      for (int i = 0; i < NB; i++) begin
        if (cnt_wsel[i]) cnt_d[i*8 +: 8] = wbyte[i];
      end
    end else if (tick) begin
      if (ctrl_q[`RTCC_BIT_CLR_MAT] && eq_now && !mat_zero) begin
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
    hold_d = hold_q;
    if (acm_ren && acm_addr == `RTCC_ADDR_COUNTER0) hold_d = cnt_q;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tb_q <= 1'b0;
      presc_q <= PRESC_START;
      cnt_q <= '0;
      match_q <= '0;
      hold_q <= '0;
    end else begin
      tb_q <= tb_d;
      presc_q <= presc_d;
      cnt_q <= cnt_d;
      match_q <= match_d;
      hold_q <= hold_d;
    end
  end

  // match outputs and read data
  always_comb begin
    fab_d = ctrl_d[`RTCC_BIT_WAKE_EN] & eq_next;
    seq_d = fab_d;
    rdata_d = rdata_q;
    if (acm_ren) begin
      rdata_d = 8'h00;
      if (acm_addr == `RTCC_ADDR_COUNTER0) begin
        rdata_d = cnt_q[7:0];
      end else if (acm_addr > `RTCC_ADDR_COUNTER0 &&
                   acm_addr <= `RTCC_ADDR_COUNTER4) begin
        rdata_d = hold_q[(acm_addr - `RTCC_ADDR_COUNTER0)*8 +: 8];
      end else if (acm_addr >= `RTCC_ADDR_MATCH0 &&
                   acm_addr <= `RTCC_ADDR_MATCH4) begin
        rdata_d = match_q[(acm_addr - `RTCC_ADDR_MATCH0)*8 +: 8];
      end else if (acm_addr >= `RTCC_ADDR_MBIT0 &&
                   acm_addr <= `RTCC_ADDR_MBIT4) begin
        rdata_d = ~(cnt_q[(acm_addr - `RTCC_ADDR_MBIT0)*8 +: 8] ^
                    match_q[(acm_addr - `RTCC_ADDR_MBIT0)*8 +: 8]);
      end else if (acm_addr == `RTCC_ADDR_CTRL) begin
        rdata_d = ctrl_q;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fab_q <= 1'b0;
      seq_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      fab_q <= fab_d;
      seq_q <= seq_d;
      rdata_q <= rdata_d;
    end
  end

  assign fabric_match_out = fab_q;
  assign sequencer_match_out = seq_q;
  assign acm_rdata = rdata_q;
  // oscillator applies the mode only while select is high
  assign crystal_mode_out =
    ctrl_q[`RTCC_BIT_MODE_HI:`RTCC_BIT_MODE_LO];
  assign crystal_select_out = ctrl_q[`RTCC_BIT_XTAL_SEL];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_release_two_clk: assert property (
    rst_q == rtcc_pkg::RTCC_ST_RESET && !ctrl_q[`RTCC_BIT_RTC_RST]
    |=> rtc_rst ##1 rtc_rst ##1 (!rtc_rst || ctrl_q[`RTCC_BIT_RTC_RST])
  ) else $error("rtc reset release not two clocks");
  a_first_tick_64: assert property (
    $rose(cnt_en) |-> presc_q == PRESC_START
  ) else $error("first tick spacing wrong");
  a_hold_disabled: assert property (
    !ctrl_q[`RTCC_BIT_CNT_EN] && ctrl_q[`RTCC_BIT_CNT_RSTB] && !rtc_rst
    && !(|cnt_wsel) |=> $stable(cnt_q)
  ) else $error("counter moved while disabled");
  a_no_preload_run: assert property (
    cnt_en && !tick && ctrl_q[`RTCC_BIT_CNT_RSTB] |=> $stable(cnt_q)
  ) else $error("counter changed without tick while enabled");
  a_match_wake: assert property (
    ctrl_q[`RTCC_BIT_WAKE_EN] && cnt_q == match_q |-> fabric_match_out
  ) else $error("match output not asserted");
  a_wake_off: assert property (
    !ctrl_q[`RTCC_BIT_WAKE_EN] |-> !fabric_match_out && !sequencer_match_out
  ) else $error("match output high with wake disabled");
  a_clear_match: assert property (
    tick && ctrl_q[`RTCC_BIT_CLR_MAT] && eq_now && !mat_zero
    && ctrl_q[`RTCC_BIT_CNT_RSTB] |=> cnt_q == '0
  ) else $error("counter not cleared on match");
  a_zero_no_clear: assert property (
    tick && mat_zero && ctrl_q[`RTCC_BIT_CNT_RSTB]
    |=> cnt_q == $past(cnt_q) + 1'b1
  ) else $error("counter cleared with zero match");
  a_cnt_rstb: assert property (
    !ctrl_q[`RTCC_BIT_CNT_RSTB] |=> cnt_q == '0
  ) else $error("counter not held at zero");
  a_seq_equal: assert property (
    fabric_match_out == sequencer_match_out
  ) else $error("match outputs differ");
  a_tick_period: assert property (
    tick |=> !tick [*1] ##0 presc_q == 7'h00
  ) else $error("prescaler did not wrap");

  c_tick: cover property (tick);
  c_clear: cover property (tick && eq_now && ctrl_q[`RTCC_BIT_CLR_MAT]);
  c_wake: cover property ($rose(fabric_match_out));
  c_release: cover property ($fell(rtc_rst));
endmodule

// *** sim/rtcc_far_model.sv ***
// far side: crystal timebase, held low while stopped
`timescale 1ns/100ps
module rtcc_far_model (
  input wire logic run,
  output logic timebase_clock
);
  initial timebase_clock = 1'b0;
  // 40 ns period, well below half the bus clock rate
  always begin
    #20;
    timebase_clock = run ? ~timebase_clock : 1'b0;
  end
endmodule

// *** sim/rtcc_top_tb.sv ***
// self-checking bench of the rtc control block
`timescale 1ns/100ps
module rtcc_top_tb;
  logic clk, nrst, run, wen, ren, tbc, fm, sm, xs;
  logic [7:0] addr, wdata, rd_v;
  logic [7:0] rdata;
  logic [1:0] xm;
  int fail_count, cmp_count;
  rtcc_top dut (.clk(clk), .nrst(nrst), .timebase_clock(tbc),
    .acm_addr(addr), .acm_wdata(wdata), .acm_wen(wen), .acm_ren(ren),
    .acm_rdata(rdata), .fabric_match_out(fm), .sequencer_match_out(sm),
    .crystal_mode_out(xm), .crystal_select_out(xs));
  rtcc_far_model far (.run(run), .timebase_clock(tbc));
  always #2.5 clk = ~clk;
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wen = 1'b1;
    @(negedge clk);
    wen = 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(negedge clk);
    addr = a;
    ren = 1'b1;
    @(negedge clk);
    ren = 1'b0;
    rd_v = rdata;
  endtask
  // both match outputs packed as {sequencer, fabric}
  function automatic logic [7:0] mo();
    return {6'h00, sm, fm};
  endfunction
  task automatic edges(int n);
    repeat (n) @(posedge tbc);
    repeat (3) @(negedge clk);
  endtask
  task automatic t_reset();
    rd(8'h58);
    chk("ctrl", rd_v, 8'h00);
    chk("match", mo(), 8'h00);
    chk("sel", {7'h00, xs}, 8'h00);
  endtask
  // rtc reset forces zero and blocks preload for two clocks after release
  task automatic t_rtc_rst();
    wr(8'h58, 8'h02);
    wr(8'h40, 8'h11);
    wr(8'h58, 8'h82);
    rd(8'h58);
    chk("ctrl", rd_v, 8'h82);
    rd(8'h40);
    chk("rtc reset", rd_v, 8'h00);
    wr(8'h58, 8'h02);
    wr(8'h40, 8'h22);
    rd(8'h40);
    chk("in release", rd_v, 8'h00);
    wr(8'h40, 8'h22);
    rd(8'h40);
    chk("released", rd_v, 8'h22);
  endtask
  task automatic t_xtal();
    for (int m = 0; m < 4; m++) begin
      wr(8'h58, {3'h0, m[1:0], 2'h0, 1'b1});
      chk("mode", {6'h00, xm}, {6'h00, m[1:0]});
      chk("sel", {7'h00, xs}, 8'h01);
    end
    wr(8'h58, 8'h00);
    chk("sel", {7'h00, xs}, 8'h00);
  endtask
  task automatic t_count();
    wr(8'h58, 8'h02);
    wr(8'h40, 8'h05);
    wr(8'h48, 8'h06);
    rd(8'h40);
    chk("preload", rd_v, 8'h05);
    wr(8'h58, 8'h66);
    edges(62);
    chk("match", mo(), 8'h00);
    edges(3);
    chk("match", mo(), 8'h03);
    wr(8'h58, 8'h26);
    edges(140);
    rd(8'h40);
    chk("held", rd_v, 8'h06);
    chk("match", mo(), 8'h03);
    wr(8'h58, 8'h66);
    wr(8'h40, 8'h33);
    rd(8'h40);
    chk("locked", rd_v, 8'h06);
    edges(60);
    rd(8'h40);
    chk("cnt", rd_v, 8'h06);
    edges(6);
    rd(8'h40);
    chk("cleared", rd_v, 8'h00);
    chk("match", mo(), 8'h00);
  endtask
  task automatic t_zero();
    wr(8'h58, 8'h02);
    wr(8'h48, 8'h00);
    wr(8'h40, 8'h09);
    rd(8'h40);
    chk("preload", rd_v, 8'h09);
    wr(8'h58, 8'h00);
    rd(8'h40);
    chk("cnt", rd_v, 8'h00);
    chk("match", mo(), 8'h00);
    rd(8'h50);
    chk("mbits", rd_v, 8'hff);
    wr(8'h58, 8'h20);
    chk("match", mo(), 8'h03);
    wr(8'h58, 8'h66);
    edges(62);
    rd(8'h40);
    chk("no tick", rd_v, 8'h00);
    edges(4);
    rd(8'h40);
    chk("zero match", rd_v, 8'h01);
    edges(120);
    rd(8'h40);
    chk("period", rd_v, 8'h01);
    edges(8);
    rd(8'h40);
    chk("period", rd_v, 8'h02);
    wr(8'h58, 8'h22);
    wr(8'h48, 8'h02);
    chk("match", mo(), 8'h03);
    wr(8'h4c, 8'h01);
    chk("match", mo(), 8'h00);
    rd(8'h54);
    chk("mbits", rd_v, 8'hfe);
    rd(8'h60);
    chk("unmapped", rd_v, 8'h00);
  endtask
  task automatic final_report();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    run = 1'b1;
    wen = 1'b0;
    ren = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_xtal();
    t_rtc_rst();
    t_count();
    t_zero();
    final_report();
  end
  initial begin
    #100us;
    fail_count++;
    final_report();
  end
endmodule
